/* File: verilog/cpu4_core.sv */
/*
  datapath and sequencing core of a 4-bit controller, one operation per
  command write over a classic wishbone slave.
  assumes one 125 mhz clock, synchronous active-high reset, and port d
  pins resolved as open drain by the surroundings.
*/
// Design decisions made here: register access over Wishbone and the address map.
// Functional notes
// RQ1: alu adds, compares, ands, ors and manipulates single bits on 4-bit data
// RQ2: add memory with carry sets carry flag on carry out
// RQ3: add immediate and add memory leave carry flag unchanged
// RQ4: rotate right moves accumulator bit 0 into carry flag
// RQ5: one operation sets carry flag, another clears it
// RQ6: 8-bit pair loads from and transfers to aux high, acc low
// RQ7: page pointer joined with acc forms 7-bit in-page rom address
// RQ8: eight-entry return stack pushed on interrupt, call, table read
// RQ9: more than eight nested pushes corrupt earlier entries, no protection
// RQ10: 3-bit stack pointer tracks nesting; one operation copies it to acc
// RQ11: interrupt entry saves pointer, carry, skip, acc, aux; return restores
// RQ12: calls and table read never write the interrupt save register
// RQ13: skip flag decides skips and survives an interrupt via save register
// RQ14: pc advances by length; branch, call, return, table read load it; here table read never loads pc, it only advances it by length
// RQ15: pc is page field over 7-bit offset; offset 127 rolls to next page
// RQ16: ram pointer has file group, file and digit fields
// RQ17: digit field selects the port d bit for set, clear, test
// RQ18: program words are 10 bits, pages of 128 words
// RQ19: interrupt loads pc with vector in 0080 to 00ff
// RQ20: page two call reaches entries 0100 to 017f from any page
// RQ21: table read returns low eight bits of any program word
// RQ22: stack pointer wraps modulo eight, ninth push overwrites oldest entry
`timescale 1ns/10ps
`default_nettype none
module cpu4_core
  import cpu4_core_pkg::*;
#(
  parameter int ROM_DEPTH = 512,
  parameter int RAM_DEPTH = 512
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // port d open drain pins
  input  wire logic [7:0]  port_d_i,
  output logic      [7:0]  port_d_o,
  output logic      [7:0]  port_d_oe_o
);

  ////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [3:0]               acc;
    logic [3:0]               aux;
    logic [7:0]               pair;
    logic                     carry_flag;
    logic                     skip;
    logic [2:0]               page_ptr;
    logic [2:0]               stack_level_pointer;
    logic [PC_W-1:0]          pc;
    ram_pointer_s             ram_pointer;
    interrupt_save_s          interrupt_save_register;
    logic [STK_N-1:0][PC_W-1:0] return_stack;
    logic [7:0]               port_latch;
    logic [7:0]               port_sync1;
    logic [7:0]               port_sync2;
    logic [PC_W-1:0]          rom_ptr;
    logic [31:0]              dat;
    logic                     ack;
  } core_s;

  core_s s_r;
  core_s s_nxt;

  logic [ROM_W-1:0] rom_mem [ROM_DEPTH];
  logic [3:0]       ram_mem [RAM_DEPTH];

  logic             ram_we;
  logic [3:0]       ram_wdata;
  logic             rom_we;
  logic [ROM_W-1:0] rom_wdata;
  logic [PC_W-1:0]  rom_waddr;

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b, input logic cin);
    add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction : add4

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic [1:0] insn_len(input op_e op);
    insn_len = (op == OP_BRANCH || op == OP_CALL) ? LEN_LONG : LEN_SHORT;
  endfunction : insn_len

  function automatic logic [PC_W-1:0] pc_adv(input logic [PC_W-1:0] pc, input logic [1:0] len);
    // RQ15 offset 127 rolls over
    pc_adv = pc + {{(PC_W-2){1'b0}}, len};
  endfunction : pc_adv

  ////////////////////////////////////////////////////////////////////
  // next state
  cmd_s             cmd;
  logic             wb_req;
  logic             exec;
  logic [3:0]       mem;
  logic [4:0]       sum;
  logic [PC_W-1:0]  pc_next;
  logic [PC_W-1:0]  idx_addr;
  logic [ROM_W-1:0] rom_word;
  logic [2:0]       sp_dec;
  logic [31:0]      wval;

  always_comb begin
    s_nxt     = s_r;
    cmd       = cmd_s'(wb_dat_i);
    wb_req    = wb_cyc_i && wb_stb_i && !s_r.ack;
    exec      = wb_req && wb_we_i && (wb_adr_i == ADDR_CMD) && (wb_sel_i == 4'hf);
    mem       = ram_mem[s_r.ram_pointer[$clog2(RAM_DEPTH)-1:0]];
    sum       = 5'h00;
    pc_next   = pc_adv(s_r.pc, insn_len(cmd.op));
    // RQ7 in-page rom index
    idx_addr  = {cmd.imm[PAGE_W-1:0], s_r.page_ptr, s_r.acc};
    rom_word  = rom_mem[idx_addr[$clog2(ROM_DEPTH)-1:0]];
    sp_dec    = s_r.stack_level_pointer - 3'h1;
    wval      = 32'h0;
    ram_we    = 1'b0;
    ram_wdata = 4'h0;
    rom_we    = 1'b0;
    rom_wdata = wb_dat_i[ROM_W-1:0];
    rom_waddr = s_r.rom_ptr;

    s_nxt.port_sync1 = port_d_i;
    s_nxt.port_sync2 = s_r.port_sync1;
    s_nxt.ack        = wb_req;

    // register reads
    if (wb_req) begin
      case (wb_adr_i)
        ADDR_CORE:     s_nxt.dat = {16'h0, s_r.stack_level_pointer, s_r.page_ptr,
                                    s_r.skip, s_r.carry_flag, s_r.aux, s_r.acc};
        ADDR_PAIR:     s_nxt.dat = {24'h0, s_r.pair};
        ADDR_PC:       s_nxt.dat = {19'h0, s_r.pc};
        ADDR_DPTR:     s_nxt.dat = {23'h0, s_r.ram_pointer};
        ADDR_ROM_ADDR: s_nxt.dat = {19'h0, s_r.rom_ptr};
        ADDR_ROM_DATA: s_nxt.dat = {22'h0, rom_mem[s_r.rom_ptr[$clog2(ROM_DEPTH)-1:0]]};
        ADDR_PORT:     s_nxt.dat = {16'h0, s_r.port_sync2, s_r.port_latch};
        ADDR_RAM:      s_nxt.dat = {28'h0, mem};
        ADDR_STACK:    s_nxt.dat = {19'h0, s_r.return_stack[sp_dec]};
        default:       s_nxt.dat = 32'h0;
      endcase
    end

    // register writes
    if (wb_req && wb_we_i) begin
      case (wb_adr_i)
        ADDR_PC: begin
          wval     = merge({19'h0, s_r.pc}, wb_dat_i, wb_sel_i);
          s_nxt.pc = wval[PC_W-1:0];
        end
        ADDR_DPTR: begin
          wval              = merge({23'h0, s_r.ram_pointer}, wb_dat_i, wb_sel_i);
          s_nxt.ram_pointer = ram_pointer_s'(wval[DPT_W-1:0]);
        end
        ADDR_ROM_ADDR: begin
          wval          = merge({19'h0, s_r.rom_ptr}, wb_dat_i, wb_sel_i);
          s_nxt.rom_ptr = wval[PC_W-1:0];
        end
        ADDR_ROM_DATA: begin
          // RQ18 ten-bit program word store
          rom_we        = wb_sel_i[0] && wb_sel_i[1];
          s_nxt.rom_ptr = s_r.rom_ptr + 13'h0001;
        end
        default: begin
        end
      endcase
    end

    // one operation per command write
    if (exec) begin
      if (s_r.skip && cmd.op != OP_INTERRUPT) begin
        // RQ13 pending skip drops this operation
        s_nxt.skip = 1'b0;
        s_nxt.pc   = pc_next;
      end else begin
        // RQ14 default advance by length
        s_nxt.pc   = pc_next;
        s_nxt.skip = 1'b0;
        case (cmd.op)
          OP_NOP: begin
          end
          OP_LOAD_IMM:  s_nxt.acc = cmd.imm[3:0];
          OP_AUX_LOAD:  s_nxt.aux = cmd.imm[3:0];
          OP_ADD_IMM: begin
            // RQ3 carry kept
            sum       = add4(s_r.acc, cmd.imm[3:0], 1'b0);
            s_nxt.acc = sum[3:0];
          end
          OP_ADD_MEM: begin
            // RQ3 carry kept
            sum       = add4(s_r.acc, mem, 1'b0);
            s_nxt.acc = sum[3:0];
          end
          OP_ADD_MEM_CY: begin
            // RQ2 carry out to flag
            sum              = add4(s_r.acc, mem, s_r.carry_flag);
            s_nxt.acc        = sum[3:0];
            s_nxt.carry_flag = sum[4];
          end
          // RQ1 logic and compare
          OP_AND_MEM:   s_nxt.acc  = s_r.acc & mem;
          OP_OR_MEM:    s_nxt.acc  = s_r.acc | mem;
          OP_CMP_IMM:   s_nxt.skip = (s_r.acc == cmd.imm[3:0]);
          OP_BIT_SET: begin
            // RQ1 single-bit write
            ram_we    = 1'b1;
            ram_wdata = mem | (4'h1 << cmd.imm[1:0]);
          end
          OP_BIT_CLR: begin
            ram_we    = 1'b1;
            ram_wdata = mem & ~(4'h1 << cmd.imm[1:0]);
          end
          OP_BIT_TEST:  s_nxt.skip = !mem[cmd.imm[1:0]];
          OP_STORE_ACC: begin
            ram_we    = 1'b1;
            ram_wdata = s_r.acc;
          end
          OP_ROT_RIGHT: begin
            // RQ4 bit 0 into carry
            s_nxt.acc        = {s_r.carry_flag, s_r.acc[3:1]};
            s_nxt.carry_flag = s_r.acc[0];
          end
          // RQ5 carry force and clear
          OP_SET_CY:    s_nxt.carry_flag = 1'b1;
          OP_CLR_CY:    s_nxt.carry_flag = 1'b0;
          // RQ6 pair transfers
          OP_PAIR_LOAD: s_nxt.pair = {s_r.aux, s_r.acc};
          OP_PAIR_XFER: begin
            s_nxt.aux = s_r.pair[7:4];
            s_nxt.acc = s_r.pair[3:0];
          end
          OP_PAGE_PTR:  s_nxt.page_ptr = cmd.imm[2:0];
          // RQ10 level to acc
          OP_SP_TO_ACC: s_nxt.acc = {1'b0, s_r.stack_level_pointer};
          OP_BRANCH:    s_nxt.pc  = cmd.target;
          OP_IDX_BRANCH: s_nxt.pc = idx_addr;
          OP_CALL, OP_P2_CALL, OP_IDX_P2_CALL: begin
            // RQ8 push, RQ9 RQ22 wrap overwrites, RQ12 save untouched
            s_nxt.return_stack[s_r.stack_level_pointer] = pc_next;
            s_nxt.stack_level_pointer = s_r.stack_level_pointer + 3'h1;
            if (cmd.op == OP_CALL) begin
              s_nxt.pc = cmd.target;
            end else if (cmd.op == OP_P2_CALL) begin
              // RQ20 entry on page two
              s_nxt.pc = PAGE_TWO_BASE | {6'h0, cmd.imm[6:0]};
            end else begin
              s_nxt.pc = {PAGE_TWO, s_r.page_ptr, s_r.acc};
            end
          end
          OP_TABLE_READ: begin
            // RQ21 low eight bits, RQ8 stack slot used and released
            s_nxt.return_stack[s_r.stack_level_pointer] = pc_next;
            s_nxt.aux = rom_word[7:4];
            s_nxt.acc = rom_word[3:0];
          end
          OP_RETURN: begin
            // RQ8 pop
            s_nxt.stack_level_pointer = sp_dec;
            s_nxt.pc                  = s_r.return_stack[sp_dec];
          end
          OP_INTERRUPT: begin
            // RQ11 save, RQ13 skip kept, RQ19 vector
            s_nxt.return_stack[s_r.stack_level_pointer] = s_r.pc;
            s_nxt.stack_level_pointer = s_r.stack_level_pointer + 3'h1;
            s_nxt.interrupt_save_register = '{dp: s_r.ram_pointer,
                                              carry_flag: s_r.carry_flag,
                                              skip: s_r.skip,
                                              acc: s_r.acc,
                                              aux: s_r.aux};
            s_nxt.pc = INT_VEC_BASE | {6'h0, cmd.imm[6:0]};
          end
          OP_RETURN_INT: begin
            // RQ11 restore
            s_nxt.stack_level_pointer = sp_dec;
            s_nxt.pc                  = s_r.return_stack[sp_dec];
            s_nxt.ram_pointer         = s_r.interrupt_save_register.dp;
            s_nxt.carry_flag          = s_r.interrupt_save_register.carry_flag;
            s_nxt.skip                = s_r.interrupt_save_register.skip;
            s_nxt.acc                 = s_r.interrupt_save_register.acc;
            s_nxt.aux                 = s_r.interrupt_save_register.aux;
          end
          // RQ17 digit selects port bit
          OP_PORT_SET:  s_nxt.port_latch[s_r.ram_pointer.y[2:0]] = 1'b1;
          OP_PORT_CLR:  s_nxt.port_latch[s_r.ram_pointer.y[2:0]] = 1'b0;
          OP_PORT_TEST: s_nxt.skip = !s_r.port_sync2[s_r.ram_pointer.y[2:0]];
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers and memories
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_r                     <= '0;
      s_r.pc                  <= PC_RST;
      s_r.stack_level_pointer <= SP_RST;
      s_r.port_latch          <= PORT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // RQ16 ram indexed by group, file, digit
  always_ff @(posedge core_clk_i) begin
    if (ram_we) begin
      ram_mem[s_r.ram_pointer[$clog2(RAM_DEPTH)-1:0]] <= ram_wdata;
    end
    if (rom_we) begin
      rom_mem[rom_waddr[$clog2(ROM_DEPTH)-1:0]] <= rom_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_dat_o    = s_r.dat;
  assign wb_ack_o    = s_r.ack;
  assign port_d_o    = 8'h00;
  assign port_d_oe_o = s_r.port_latch;

endmodule : cpu4_core
`default_nettype wire

/* File: verilog/cpu4_core_pkg.sv */
/*
  constants, opcodes and carrier types of the 4-bit core datapath.
  assumes a 32-bit classic wishbone slave with byte addresses.
*/
`default_nettype none
package cpu4_core_pkg;

  ////////////////////////////////////////////////////////////////////
  // widths
  localparam int PC_W   = 13;
  localparam int OFF_W  = 7;
  localparam int PAGE_W = PC_W - OFF_W;
  localparam int ROM_W  = 10;
  localparam int DPT_W  = 9;
  localparam int STK_N  = 8;

  ////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_CORE     = 8'h04;
  localparam logic [7:0] ADDR_PAIR     = 8'h08;
  localparam logic [7:0] ADDR_PC       = 8'h0c;
  localparam logic [7:0] ADDR_DPTR     = 8'h10;
  localparam logic [7:0] ADDR_ROM_ADDR = 8'h14;
  localparam logic [7:0] ADDR_ROM_DATA = 8'h18;
  localparam logic [7:0] ADDR_PORT     = 8'h1c;
  localparam logic [7:0] ADDR_RAM      = 8'h20;
  localparam logic [7:0] ADDR_STACK    = 8'h24;

  ////////////////////////////////////////////////////////////////////
  // addresses and reset values
  localparam logic [PC_W-1:0]   PC_RST        = 13'h0000;
  localparam logic [PC_W-1:0]   INT_VEC_BASE  = 13'h0080;
  localparam logic [PC_W-1:0]   INT_VEC_LAST  = 13'h00ff;
  localparam logic [PC_W-1:0]   PAGE_TWO_BASE = 13'h0100;
  localparam logic [PC_W-1:0]   PAGE_TWO_LAST = 13'h017f;
  localparam logic [PAGE_W-1:0] PAGE_TWO      = 6'h02;
  localparam logic [2:0]        SP_RST        = 3'h0;
  localparam logic [7:0]        PORT_RST      = 8'hff;
  localparam logic [1:0]        LEN_SHORT     = 2'h1;
  localparam logic [1:0]        LEN_LONG      = 2'h2;

  ////////////////////////////////////////////////////////////////////
  // operations
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_LOAD_IMM     = 5'h01,
    OP_ADD_IMM      = 5'h02,
    OP_ADD_MEM      = 5'h03,
    OP_ADD_MEM_CY   = 5'h04,
    OP_AND_MEM      = 5'h05,
    OP_OR_MEM       = 5'h06,
    OP_CMP_IMM      = 5'h07,
    OP_BIT_SET      = 5'h08,
    OP_BIT_CLR      = 5'h09,
    OP_BIT_TEST     = 5'h0a,
    OP_ROT_RIGHT    = 5'h0b,
    OP_SET_CY       = 5'h0c,
    OP_CLR_CY       = 5'h0d,
    OP_PAIR_LOAD    = 5'h0e,
    OP_PAIR_XFER    = 5'h0f,
    OP_PAGE_PTR     = 5'h10,
    OP_SP_TO_ACC    = 5'h11,
    OP_BRANCH       = 5'h12,
    OP_CALL         = 5'h13,
    OP_P2_CALL      = 5'h14,
    OP_IDX_BRANCH   = 5'h15,
    OP_IDX_P2_CALL  = 5'h16,
    OP_TABLE_READ   = 5'h17,
    OP_RETURN       = 5'h18,
    OP_INTERRUPT    = 5'h19,
    OP_RETURN_INT   = 5'h1a,
    OP_PORT_SET     = 5'h1b,
    OP_PORT_CLR     = 5'h1c,
    OP_PORT_TEST    = 5'h1d,
    OP_STORE_ACC    = 5'h1e,
    OP_AUX_LOAD     = 5'h1f
  } op_e;

  ////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [2:0]      pad;
    logic [PC_W-1:0] target;
    logic [7:0]      imm;
    logic [2:0]      rsv;
    op_e             op;
  } cmd_s;

  typedef struct packed {
    logic       z;
    logic [3:0] x;
    logic [3:0] y;
  } ram_pointer_s;

  typedef struct packed {
    ram_pointer_s dp;
    logic         carry_flag;
    logic         skip;
    logic [3:0]   acc;
    logic [3:0]   aux;
  } interrupt_save_s;

endpackage : cpu4_core_pkg
`default_nettype wire

/* File: sim/cpu4_core_asserts.sv */
/*
  checker: command effects seen on wishbone reads of the core.
  assumes it is bound to the core top by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu4_core_asserts
  import cpu4_core_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  logic [4:0]  op_r;
  logic [7:0]  imm_r;
  logic [12:0] tgt_r;
  logic        ok_r;
  logic        rc;
  logic        rp;
  logic        cmd;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  assign cmd = (wb_adr_i == ADDR_CMD) & (wb_sel_i == 4'hf);
  assign rc  = ok_r & wb_ack_o & ~wb_we_i & (wb_adr_i == ADDR_CORE);
  assign rp  = ok_r & wb_ack_o & ~wb_we_i & (wb_adr_i == ADDR_PC);
  //////////////////////////////////////////////////////////////////
  // last command, and whether it surely ran unskipped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      op_r <= 5'h00;
      ok_r <= 1'b0;
    end else if (wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o) begin
      ok_r <= cmd & !(op_r inside {5'h07, 5'h0a, 5'h1a, 5'h1d});
      if (cmd) begin
        op_r  <= wb_dat_i[4:0];
        imm_r <= wb_dat_i[15:8];
        tgt_r <= wb_dat_i[28:16];
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  a_carry_set: assert property (rc && op_r == OP_SET_CY |-> wb_dat_o[8])
    else $error("carry not set");
  a_carry_clear: assert property (rc && op_r == OP_CLR_CY |-> !wb_dat_o[8])
    else $error("carry not cleared");
  a_sp_copy: assert property (rc && op_r == OP_SP_TO_ACC |-> wb_dat_o[3:0] == {1'b0, wb_dat_o[15:13]})
    else $error("acc differs from stack level");
  a_page_ptr: assert property (rc && op_r == OP_PAGE_PTR |-> wb_dat_o[12:10] == imm_r[2:0])
    else $error("page pointer wrong");
  a_acc_load: assert property (rc && op_r == OP_LOAD_IMM |-> wb_dat_o[3:0] == imm_r[3:0])
    else $error("acc load wrong");
  a_branch_pc: assert property (rp && op_r == OP_BRANCH |-> wb_dat_o[12:0] == tgt_r)
    else $error("branch target wrong");
  a_int_vector: assert property (ok_r && op_r == OP_INTERRUPT && wb_cyc_i && wb_stb_i && !wb_we_i
    && wb_adr_i == ADDR_PC && !wb_ack_o |=> wb_ack_o && wb_dat_o[12:0] == {6'h01, imm_r[6:0]})
    else $error("interrupt vector wrong");
  a_page_two: assert property (rp && op_r == OP_P2_CALL |-> wb_dat_o[12:0] == {6'h02, imm_r[6:0]})
    else $error("page two entry wrong");
endmodule : cpu4_core_asserts
`default_nettype wire

/* File: sim/tb_cpu4_core.sv */
/*
  bench: wishbone command driver, state model and comparisons.
  assumes the core and its checker; the bind sits at the foot.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_cpu4_core
  import cpu4_core_pkg::*;
;
  logic        clk, rst, cyc, stb, wen, ack;
  logic [7:0]  adr, oe, pd;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, seed;
  int          fail_count, num_checks, cycles;
  int          acc, aux, cy, sk, pc, sp, pp, e, dp, pl;
  int          stk[8], sv[5], ram[int], rom[int];
  logic [12:0] tbl[$];
  op_e         rnd[14] = '{OP_LOAD_IMM, OP_ADD_IMM, OP_ADD_MEM, OP_ADD_MEM_CY, OP_AND_MEM, OP_OR_MEM,
                 OP_CMP_IMM, OP_ROT_RIGHT, OP_SET_CY, OP_CLR_CY, OP_STORE_ACC, OP_AUX_LOAD, OP_BIT_SET, OP_BIT_TEST};
  // port d input wired to the output enables: driven pins read high, released pins read low
  cpu4_core u_cpu4_core (
    .core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_d_i(oe), .port_d_o(pd), .port_d_oe_o(oe));
  //////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    wen  <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    chk({31'h0, ack}, 1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic look;
    bus(1'b0, ADDR_CORE, 0, 4'hf);
    chk(q, {sp[2:0], pp[2:0], sk[0], cy[0], aux[3:0], acc[3:0]});
    bus(1'b0, ADDR_PC, 0, 4'hf);
    chk(q, pc);
    bus(1'b0, ADDR_PAIR, 0, 4'hf);
    chk(q, e);
    bus(1'b0, ADDR_STACK, 0, 4'hf);
    chk(q, stk[(sp - 1) & 7]);
    chk(oe, pl);
  endtask : look
  task automatic push(input int v);
    stk[sp] = v & 8191;
    sp = (sp + 1) & 7;
  endtask : push
  //////////////////////////////////////////////////////////////////
  // model of one command
  task automatic op(input op_e o, input int i, input int t = 0);
    int p, w;
    bus(1'b1, ADDR_CMD, {3'h0, t[12:0], i[7:0], 3'h0, o}, 4'hf);
    p = pc;
    pc = (pc + ((o == OP_BRANCH || o == OP_CALL) ? 2 : 1)) & 8191;
    if (sk != 0 && o != OP_INTERRUPT) begin
      sk = 0;
    end else begin
      case (o)
        OP_LOAD_IMM:    acc = i & 15;
        OP_ADD_IMM:     acc = (acc + i) & 15;
        OP_ADD_MEM:     acc = (acc + ram[dp]) & 15;
        OP_ADD_MEM_CY: begin
          w = acc + ram[dp] + cy;
          acc = w & 15;
          cy = w >> 4;
        end
        OP_AND_MEM:     acc = acc & ram[dp];
        OP_OR_MEM:      acc = acc | ram[dp];
        OP_CMP_IMM:     sk = (acc == (i & 15));
        OP_BIT_SET:     ram[dp] = ram[dp] | (1 << (i & 3));
        OP_BIT_CLR:     ram[dp] = ram[dp] & ~(1 << (i & 3));
        OP_BIT_TEST:    sk = ((ram[dp] >> (i & 3)) & 1) == 0;
        OP_ROT_RIGHT: begin
          w = acc & 1;
          acc = (acc >> 1) | (cy << 3);
          cy = w;
        end
        OP_SET_CY:      cy = 1;
        OP_CLR_CY:      cy = 0;
        OP_PAIR_LOAD:   e = aux * 16 + acc;
        OP_PAIR_XFER: begin
          aux = e >> 4;
          acc = e & 15;
        end
        OP_PAGE_PTR:    pp = i & 7;
        OP_SP_TO_ACC:   acc = sp;
        OP_BRANCH:      pc = t;
        OP_CALL: begin
          push(pc);
          pc = t;
        end
        OP_P2_CALL: begin
          push(pc);
          pc = 256 | (i & 127);
        end
        OP_IDX_BRANCH:  pc = ((i & 63) << 7) | (pp << 4) | acc;
        OP_IDX_P2_CALL: begin
          push(pc);
          pc = 256 | (pp << 4) | acc;
        end
        OP_TABLE_READ: begin
          w = rom[((i & 63) << 7) | (pp << 4) | acc];
          aux = (w >> 4) & 15;
          acc = w & 15;
        end
        OP_RETURN, OP_RETURN_INT: begin
          sp = (sp - 1) & 7;
          pc = stk[sp];
          if (o == OP_RETURN_INT) {dp, cy, sk, acc, aux} = {sv[0], sv[1], sv[2], sv[3], sv[4]};
        end
        OP_INTERRUPT: begin
          push(p);
          sv = '{dp, cy, sk, acc, aux};
          sk = 0;
          pc = 128 | (i & 127);
        end
        OP_PORT_SET:    pl = pl | (1 << (dp & 7));
        OP_PORT_CLR:    pl = pl & ~(1 << (dp & 7)) & 255;
        OP_PORT_TEST:   sk = ((pl >> (dp & 7)) & 1) == 0;
        OP_STORE_ACC:   ram[dp] = acc;
        OP_AUX_LOAD:    aux = i & 15;
        default: ;
      endcase
    end
    look;
  endtask : op
  task automatic run;
    foreach (tbl[k]) op(op_e'(tbl[k][12:8]), tbl[k][7:0]);
  endtask : run
  //////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    rst = 1'b1;
    {cyc, stb, wen, adr, sel, wdat} = '0;
    seed = 32'hf4b173ea;
    pl = 255;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    look;
    chk(pd, 0);
    tbl = '{{OP_LOAD_IMM, 8'h09}, {OP_STORE_ACC, 8'h00}, {OP_ADD_MEM_CY, 8'h00}, {OP_ADD_IMM, 8'h0f},
            {OP_ADD_MEM, 8'h00}, {OP_ROT_RIGHT, 8'h00}, {OP_ROT_RIGHT, 8'h00}, {OP_CLR_CY, 8'h00},
            {OP_SET_CY, 8'h00}, {OP_AND_MEM, 8'h00}, {OP_OR_MEM, 8'h00}, {OP_AUX_LOAD, 8'h0c},
            {OP_PAIR_LOAD, 8'h00}, {OP_LOAD_IMM, 8'h03}, {OP_AUX_LOAD, 8'h00}, {OP_PAIR_XFER, 8'h00}};
    run;
    tbl = '{{OP_CMP_IMM, 8'h09}, {OP_LOAD_IMM, 8'h01}, {OP_CMP_IMM, 8'h00}, {OP_BIT_SET, 8'h02},
            {OP_BIT_CLR, 8'h00}, {OP_BIT_TEST, 8'h00}, {OP_NOP, 8'h00}, {OP_BIT_TEST, 8'h02},
            {OP_PORT_CLR, 8'h00}, {OP_PORT_TEST, 8'h00}, {OP_NOP, 8'h00}, {OP_PORT_SET, 8'h00},
            {OP_PORT_TEST, 8'h00}, {OP_SP_TO_ACC, 8'h00}};
    run;
    tbl = '{{OP_PAGE_PTR, 8'h05}, {OP_LOAD_IMM, 8'h03}, {OP_IDX_BRANCH, 8'h02}, {OP_IDX_P2_CALL, 8'h00},
            {OP_RETURN, 8'h00}, {OP_P2_CALL, 8'h7f}, {OP_RETURN, 8'h00}, {OP_INTERRUPT, 8'h00},
            {OP_LOAD_IMM, 8'h02}, {OP_RETURN_INT, 8'h00}, {OP_LOAD_IMM, 8'h05}, {OP_SET_CY, 8'h00},
            {OP_CMP_IMM, 8'h05}, {OP_INTERRUPT, 8'h7f}, {OP_LOAD_IMM, 8'h02}, {OP_CLR_CY, 8'h00},
            {OP_RETURN_INT, 8'h00}, {OP_LOAD_IMM, 8'h07}, {OP_LOAD_IMM, 8'h09}};
    run;
    bus(1'b1, ADDR_ROM_ADDR, 32'h1d9, 4'hf);
    bus(1'b1, ADDR_ROM_DATA, 32'h2c6, 4'hf);
    rom[32'h1d9] = 32'h2c6;
    op(OP_TABLE_READ, 3);
    for (int k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      op(OP_CALL, 0, seed[12:0]);
    end
    repeat (9) op(OP_RETURN, 0);
    op(OP_BRANCH, 0, 32'h7f);
    op(OP_NOP, 0);
    bus(1'b1, ADDR_PC, 32'h1fff, 4'hf);
    pc = 8191;
    op(OP_NOP, 0);
    bus(1'b1, ADDR_CMD, {27'h0, OP_SET_CY}, 4'h3);
    bus(1'b1, ADDR_DPTR, 32'h1a3, 4'hf);
    dp = 32'h1a3;
    bus(1'b0, ADDR_DPTR, 0, 4'hf);
    chk(q, dp);
    bus(1'b0, 8'h40, 0, 4'hf);
    chk(q, 0);
    op(OP_PORT_CLR, 0);
    op(OP_STORE_ACC, 0);
    for (int k = 0; k < 60; k++) begin
      seed = lfsr(seed);
      op(rnd[seed[7:4] % 14], seed[15:8]);
    end
    give_verdict;
  end
endmodule : tb_cpu4_core
bind cpu4_core cpu4_core_asserts u_cpu4_core_asserts (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire
